// *** e1s_params.svh ***
`ifndef E1S_PARAMS_SVH
`define E1S_PARAMS_SVH

////////////////////////////////////////////////////////////////////////////////
// Register addresses on the microprocessor port.
`define E1S_ADDR_SYNC     5'h10
`define E1S_ADDR_FAS      5'h11
`define E1S_ADDR_TIMER    5'h12
`define E1S_ADDR_NFAS     5'h13

// Reset values: all alignments start lost.
`define E1S_SYNC_RESET    8'he0
`define E1S_TIMER_RESET   8'h00
`define E1S_CAPT_RESET    8'h00

// Timer status field positions.
`define E1S_TMR_HALF      7
`define E1S_TMR_ONE       6
`define E1S_TMR_T1        5
`define E1S_TMR_T2        4
`define E1S_TMR_LONG      3
`define E1S_TMR_SHORT     2
`define E1S_TMR_MS        1
`define E1S_TMR_KEEP      0

// Timing.
`define E1S_CLK_PERIOD_NS 50
`define E1S_MS_NS         1000000
`define E1S_MS_CYCLES     (`E1S_MS_NS / `E1S_CLK_PERIOD_NS)
`define E1S_SHORT_MS      9'h008
`define E1S_LONG_MS       9'h190
`define E1S_HALF_SEC_MS   9'h1f4
`define E1S_LOSS_MS       9'h064
`define E1S_REGAIN_MS     9'h00a
`define E1S_KEEP_MS       9'h064
`endif

// *** e1s_pkg.sv ***
package e1s_pkg;
    typedef logic [7:0] e1s_byte_t;

    // Indications from the receive framer, one clock domain with this block.
    typedef struct packed {
        logic basic_loss;
        logic sig_multiframe_loss;
        logic crc4_multiframe_loss;
        logic crc4_sync;
        logic non_normal;
        logic all_ones_alarm;
    } e1s_rx_s;

    // Static operating options.
    typedef struct packed {
        logic maintenance;
        logic auto_interwork;
        logic free_run;
    } e1s_cfg_s;

    typedef enum logic [3:0] {
        E1S_CRC_IDLE    = 4'b0001,
        E1S_CRC_SEARCH  = 4'b0010,
        E1S_CRC_ALIGNED = 4'b0100,
        E1S_CRC_SPARE   = 4'b1000
    } e1s_crc_e;
endpackage

// *** e1s_persist.sv ***
`include "e1s_params.svh"
// Persistence timer: raises hit once cond has held for limit millisecond ticks.
module e1s_persist
    import e1s_pkg::*;
(
    // Clock and reset.
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    // Condition and time base.
    input  wire logic       ms_tick,
    input  wire logic       cond,
    input  wire logic [8:0] limit,
    // Result.
    output logic            hit
);
    logic [8:0] cnt_reg;
    logic [8:0] cnt_next;
    logic       hit_reg;
    logic       hit_next;

    // Any drop of the condition restarts the count, so glitches never accumulate.
    always_comb begin
        cnt_next = cnt_reg;
        hit_next = 1'b0;
        if (!cond) begin
            cnt_next = 9'h000;
        end else begin
            if (ms_tick && (cnt_reg != limit)) begin
                cnt_next = cnt_reg + 9'h001;
            end
            hit_next = (cnt_reg == limit);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cnt_reg <= 9'h000;
            hit_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            hit_reg <= hit_next;
        end
    end

    assign hit = hit_reg;
endmodule

// *** e1s_sync_status.sv ***
`include "e1s_params.svh"
// Receive synchronisation, timer and overhead-bit status bank.
module e1s_sync_status
    import e1s_pkg::*;
#(
    parameter int MS_CYCLES = `E1S_MS_CYCLES
)
(
    // Clock and reset.
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    // Microprocessor port pins.
    input  wire logic       cpu_cs_n,
    input  wire logic       cpu_rd_n,
    input  wire logic [4:0] cpu_addr,
    output logic [7:0]      cpu_data_out,
    output logic            cpu_data_oe,
    // Receive framer indications and operating options.
    input  wire e1s_rx_s    rx,
    input  wire e1s_cfg_s   cfg,
    input  wire logic       ebit_valid,
    input  wire logic [1:0] ebit_pair,
    input  wire logic       fas_valid,
    input  wire e1s_byte_t  fas_word,
    input  wire logic       nfas_valid,
    input  wire e1s_byte_t  nfas_word,
    // Frame search request.
    output logic            force_reframe
);

    ////////////////////////////////////////////////////////////////////////////
    // Register read decode, used by the data path only; the enable follows any read.
    function automatic logic e1s_hit(input logic [4:0] a);
        e1s_hit = (a >= `E1S_ADDR_SYNC) && (a <= `E1S_ADDR_NFAS);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: strobes and address are asynchronous to ref_clk.
    logic [6:0] pin_s1_reg;
    logic [6:0] pin_s2_reg;
    logic       rd_act;
    logic [4:0] rd_addr;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pin_s1_reg <= 7'h7f;
            pin_s2_reg <= 7'h7f;
        end else begin
            pin_s1_reg <= {cpu_cs_n, cpu_rd_n, cpu_addr};
            pin_s2_reg <= pin_s1_reg;
        end
    end

    assign rd_act  = !pin_s2_reg[6] && !pin_s2_reg[5];
    assign rd_addr = pin_s2_reg[4:0];

    ////////////////////////////////////////////////////////////////////////////
    // Millisecond base; once CRC-4 aligned it is pulled onto the received sync.
    logic [15:0] ms_cnt_reg;
    logic [15:0] ms_cnt_next;
    logic        ms_tick;
    e1s_crc_e    crc_reg;
    e1s_crc_e    crc_next;

    assign ms_tick = (ms_cnt_reg == 16'(MS_CYCLES - 1)) ||
                     ((crc_reg == E1S_CRC_ALIGNED) && rx.crc4_sync);

    always_comb begin
        ms_cnt_next = ms_cnt_reg + 16'h0001;
        if (ms_tick) begin
            ms_cnt_next = 16'h0000;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ms_cnt_reg <= 16'h0000;
        end else begin
            ms_cnt_reg <= ms_cnt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // CRC-4 multiframe search with its 8 ms and 400 ms timers.
    logic [8:0] crc_ms_reg;
    logic [8:0] crc_ms_next;
    logic       reframe_reg;
    logic       reframe_next;
    logic       iwk_reg;
    logic       iwk_next;
    logic       force_reg;
    logic       force_next;
    logic       short_exp;
    logic       long_exp;

    assign short_exp = (crc_reg == E1S_CRC_SEARCH) && ms_tick && (crc_ms_reg == `E1S_SHORT_MS - 9'h001);
    assign long_exp  = (crc_reg == E1S_CRC_SEARCH) && ms_tick && (crc_ms_reg == `E1S_LONG_MS - 9'h001);

    always_comb begin
        crc_next     = crc_reg;
        crc_ms_next  = crc_ms_reg;
        reframe_next = reframe_reg;
        iwk_next     = iwk_reg;
        force_next   = 1'b0;
        case (crc_reg)
            E1S_CRC_IDLE: begin
                crc_ms_next  = 9'h000;
                reframe_next = 1'b0;
                if (!rx.basic_loss) begin
                    crc_next = E1S_CRC_SEARCH;
                end
            end
            E1S_CRC_SEARCH: begin
                if (ms_tick) begin
                    crc_ms_next = long_exp ? 9'h000 : crc_ms_reg + 9'h001;
                end
                if (short_exp) begin
                    reframe_next = 1'b1;
                    force_next   = cfg.maintenance && !cfg.auto_interwork;
                end
                if (long_exp) begin
                    iwk_next = 1'b0;
                end
                if (rx.basic_loss) begin
                    crc_next = E1S_CRC_IDLE;
                end else if (!rx.crc4_multiframe_loss) begin
                    crc_next     = E1S_CRC_ALIGNED;
                    reframe_next = short_exp;
                end
            end
            E1S_CRC_ALIGNED: begin
                crc_ms_next  = 9'h000;
                reframe_next = 1'b0;
                iwk_next     = 1'b1;
                if (rx.basic_loss) begin
                    crc_next = E1S_CRC_IDLE;
                end else if (rx.crc4_multiframe_loss) begin
                    crc_next = E1S_CRC_SEARCH;
                end
            end
            default: begin
                crc_next = E1S_CRC_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            crc_reg     <= E1S_CRC_IDLE;
            crc_ms_reg  <= 9'h000;
            reframe_reg <= 1'b0;
            iwk_reg     <= 1'b0;
            force_reg   <= 1'b0;
        end else begin
            crc_reg     <= crc_next;
            crc_ms_reg  <= crc_ms_next;
            reframe_reg <= reframe_next;
            iwk_reg     <= iwk_next;
            force_reg   <= force_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Persistence timers for the long-loss, loss, regain and keep-alive bits.
    logic long_hit;
    logic loss_hit;
    logic regain_hit;
    logic keep_hit;

    e1s_persist u_long (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .ms_tick (ms_tick),
        .cond    (rx.basic_loss),
        .limit   (`E1S_LOSS_MS),
        .hit     (long_hit)
    );

    e1s_persist u_loss (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .ms_tick (ms_tick),
        .cond    (rx.basic_loss && !cfg.free_run),
        .limit   (`E1S_LOSS_MS),
        .hit     (loss_hit)
    );

    e1s_persist u_regain (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .ms_tick (ms_tick),
        .cond    (!rx.basic_loss && !rx.non_normal && !cfg.free_run),
        .limit   (`E1S_REGAIN_MS),
        .hit     (regain_hit)
    );

    e1s_persist u_keep (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .ms_tick (ms_tick),
        .cond    (rx.all_ones_alarm),
        .limit   (`E1S_KEEP_MS),
        .hit     (keep_hit)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Status and capture registers; line events and the timers change them, never reads.
    e1s_byte_t  sync_reg;
    e1s_byte_t  sync_next;
    e1s_byte_t  timer_reg;
    e1s_byte_t  timer_next;
    e1s_byte_t  fas_reg;
    e1s_byte_t  fas_next;
    e1s_byte_t  nfas_reg;
    e1s_byte_t  nfas_next;
    logic [1:0] ebit_reg;
    logic [1:0] ebit_next;
    logic [8:0] sec_ms_reg;
    logic [8:0] sec_ms_next;

    always_comb begin
        ebit_next = ebit_valid ? ebit_pair : ebit_reg;
        fas_next  = fas_valid ? fas_word : fas_reg;
        nfas_next = nfas_valid ? nfas_word : nfas_reg;
        sync_next = {rx.basic_loss,
                     rx.sig_multiframe_loss,
                     rx.crc4_multiframe_loss,
                     ebit_reg,
                     reframe_reg,
                     long_hit && rx.basic_loss,
                     iwk_reg};
        timer_next  = timer_reg;
        sec_ms_next = sec_ms_reg;
        // Free-running mode has no line timing, so the second timers are held at zero.
        if (cfg.free_run) begin
            sec_ms_next                = 9'h000;
            timer_next[`E1S_TMR_HALF]  = 1'b0;
            timer_next[`E1S_TMR_ONE]   = 1'b0;
        end else if (ms_tick) begin
            sec_ms_next = sec_ms_reg + 9'h001;
            if (sec_ms_reg == `E1S_HALF_SEC_MS - 9'h001) begin
                sec_ms_next               = 9'h000;
                timer_next[`E1S_TMR_HALF] = !timer_reg[`E1S_TMR_HALF];
                timer_next[`E1S_TMR_ONE]  = timer_reg[`E1S_TMR_ONE] ^ timer_reg[`E1S_TMR_HALF];
            end
        end
        if (loss_hit) begin
            timer_next[`E1S_TMR_T1] = 1'b1;
        end
        if (regain_hit || cfg.free_run) begin
            timer_next[`E1S_TMR_T1] = 1'b0;
        end
        timer_next[`E1S_TMR_T2]    = regain_hit && !cfg.free_run;
        timer_next[`E1S_TMR_LONG]  = timer_reg[`E1S_TMR_LONG] ^ long_exp;
        timer_next[`E1S_TMR_SHORT] = timer_reg[`E1S_TMR_SHORT] ^ short_exp;
        timer_next[`E1S_TMR_MS]    = timer_reg[`E1S_TMR_MS] ^ ms_tick;
        timer_next[`E1S_TMR_KEEP]  = keep_hit && rx.all_ones_alarm;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sync_reg   <= `E1S_SYNC_RESET;
            timer_reg  <= `E1S_TIMER_RESET;
            fas_reg    <= `E1S_CAPT_RESET;
            nfas_reg   <= `E1S_CAPT_RESET;
            ebit_reg   <= 2'h0;
            sec_ms_reg <= 9'h000;
        end else begin
            sync_reg   <= sync_next;
            timer_reg  <= timer_next;
            fas_reg    <= fas_next;
            nfas_reg   <= nfas_next;
            ebit_reg   <= ebit_next;
            sec_ms_reg <= sec_ms_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port: pure multiplexer, there are no write or clear-on-read paths.
    e1s_byte_t rdata_reg;
    e1s_byte_t rdata_next;
    logic      oe_reg;
    logic      oe_next;

    always_comb begin
        oe_next    = rd_act;
        rdata_next = 8'h00;
        if (rd_act && e1s_hit(rd_addr)) begin
            case (rd_addr)
                `E1S_ADDR_SYNC:  rdata_next = sync_reg;
                `E1S_ADDR_FAS:   rdata_next = fas_reg;
                `E1S_ADDR_TIMER: rdata_next = timer_reg;
                `E1S_ADDR_NFAS:  rdata_next = nfas_reg;
                default:         rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rdata_reg <= 8'h00;
            oe_reg    <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            oe_reg    <= oe_next;
        end
    end

    assign cpu_data_out  = rdata_reg;
    assign cpu_data_oe   = oe_reg;
    assign force_reframe = force_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    AST_SYNC_LOSS: assert property (rx.basic_loss |=> sync_reg[7] ##1 sync_reg[7] == $past(rx.basic_loss))
        else $error("Basic frame loss bit wrong.");
    AST_SIG_MF: assert property (sync_reg[6] == $past(rx.sig_multiframe_loss))
        else $error("Signalling multiframe bit wrong.");
    AST_CRC_MF: assert property (sync_reg[5] == $past(rx.crc4_multiframe_loss))
        else $error("CRC-4 multiframe bit wrong.");
    AST_EBITS: assert property (ebit_valid |=> ##1 sync_reg[4:3] == $past(ebit_pair, 2))
        else $error("E-bits not reported.");
    AST_REFRAME: assert property ($rose(reframe_reg) |-> $past(short_exp))
        else $error("Reframe flag set without 8 ms expiry.");
    AST_FORCE: assert property (force_reframe |-> reframe_reg && $past(cfg.maintenance && !cfg.auto_interwork))
        else $error("Forced search without maintenance option.");
    AST_LONG_LOSS: assert property (!rx.basic_loss |=> !sync_reg[1])
        else $error("Long-loss alarm held after alignment.");
    AST_IWK: assert property ((crc_reg == E1S_CRC_ALIGNED) |=> iwk_reg)
        else $error("Interworking not shown on aligned link.");
    AST_FAS_CAPT: assert property (fas_valid |=> fas_reg == $past(fas_word))
        else $error("Frame alignment word not captured.");
    AST_NFAS_CAPT: assert property (nfas_valid |=> nfas_reg == $past(nfas_word))
        else $error("Non-alignment word not captured.");
    AST_FREE_RUN: assert property (cfg.free_run |=> !timer_reg[`E1S_TMR_HALF] && !timer_reg[`E1S_TMR_T2])
        else $error("Second timers run in free-running mode.");
    AST_MS_TOGGLE: assert property (ms_tick |=> timer_reg[`E1S_TMR_MS] != $past(timer_reg[`E1S_TMR_MS]))
        else $error("Millisecond bit did not toggle.");
    AST_KEEP: assert property (!rx.all_ones_alarm |=> !timer_reg[`E1S_TMR_KEEP])
        else $error("Keep-alive held after alarm fell.");
    AST_T1_CLEAR: assert property (regain_hit |=> !timer_reg[`E1S_TMR_T1])
        else $error("Loss persistence bit not cleared on regain.");
endmodule

// *** e1s_far_end.sv ***
// Far-end line terminal as seen through the framer: overhead words and E-bits.
module e1s_far_end
    import e1s_pkg::*;
(
    // Clock.
    input  wire logic ref_clk,
    // Overhead words and E-bits.
    output logic       fas_valid,
    output e1s_byte_t  fas_word,
    output logic       nfas_valid,
    output e1s_byte_t  nfas_word,
    output logic       ebit_valid,
    output logic [1:0] ebit_pair
);
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////////
    // Idle values; data lines show the inverse once a word has gone by, so a
    // stale capture cannot match by luck.
    initial begin
        fas_valid  = 1'b0;
        fas_word   = 8'h00;
        nfas_valid = 1'b0;
        nfas_word  = 8'h00;
        ebit_valid = 1'b0;
        ebit_pair  = 2'h0;
    end

    // One frame-alignment word, bit one of the slot in the top bit.
    task automatic send_fas(input e1s_byte_t w);
        @(negedge ref_clk);
        fas_word  = w;
        fas_valid = 1'b1;
        @(negedge ref_clk);
        fas_valid = 1'b0;
        fas_word  = ~w;
    endtask

    // One non-frame-alignment word.
    task automatic send_nfas(input e1s_byte_t w);
        @(negedge ref_clk);
        nfas_word  = w;
        nfas_valid = 1'b1;
        @(negedge ref_clk);
        nfas_valid = 1'b0;
        nfas_word  = ~w;
    endtask

    // E-bits of one multiframe, {E1,E2}.
    task automatic send_ebits(input logic [1:0] p);
        @(negedge ref_clk);
        ebit_pair  = p;
        ebit_valid = 1'b1;
        @(negedge ref_clk);
        ebit_valid = 1'b0;
        ebit_pair  = ~p;
    endtask
endmodule

// *** e1s_sync_status_bench.sv ***
// Self-checking bench for the receive status bank.
module e1s_sync_status_bench
    import e1s_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // A simulated millisecond must outlast several register reads, or the schedule drifts.
    localparam int MS = 50;

    logic       ref_clk;
    logic       rst_n;
    logic       cpu_cs_n;
    logic       cpu_rd_n;
    logic [4:0] cpu_addr;
    logic [7:0] cpu_data_out;
    logic       cpu_data_oe;
    e1s_rx_s    rx;
    e1s_cfg_s   cfg;
    logic       ebit_valid;
    logic [1:0] ebit_pair;
    logic       fas_valid;
    e1s_byte_t  fas_word;
    logic       nfas_valid;
    e1s_byte_t  nfas_word;
    logic       force_reframe;
    int         n_fail;
    int         compares;
    int         cyc;
    int         n_force;
    logic [7:0] d1;
    logic [7:0] d2;

    ////////////////////////////////////////////////////////////////////////////
    // Design and far end.
    e1s_sync_status #(.MS_CYCLES(MS)) uut (
        .ref_clk(ref_clk), .rst_n(rst_n), .cpu_cs_n(cpu_cs_n), .cpu_rd_n(cpu_rd_n),
        .cpu_addr(cpu_addr), .cpu_data_out(cpu_data_out), .cpu_data_oe(cpu_data_oe),
        .rx(rx), .cfg(cfg), .ebit_valid(ebit_valid), .ebit_pair(ebit_pair),
        .fas_valid(fas_valid), .fas_word(fas_word), .nfas_valid(nfas_valid),
        .nfas_word(nfas_word), .force_reframe(force_reframe)
    );

    e1s_far_end far (
        .ref_clk(ref_clk), .fas_valid(fas_valid), .fas_word(fas_word),
        .nfas_valid(nfas_valid), .nfas_word(nfas_word),
        .ebit_valid(ebit_valid), .ebit_pair(ebit_pair)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Clock, cycle count since reset release and frame-search request count.
    initial ref_clk = 1'b0;
    always #25 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            cyc     <= 0;
            n_force <= 0;
        end else begin
            cyc <= cyc + 1;
            if (force_reframe === 1'b1) begin
                n_force <= n_force + 1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Verdict and closing.
    task automatic report_and_stop();
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Compare of a single value: a flag, a count or a masked register byte.
    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Read over the processor port; the strobes stay active until data is sampled.
    task automatic cpu_read(input logic [4:0] a, output logic [7:0] d);
        cpu_cs_n = 1'b0;
        cpu_rd_n = 1'b0;
        cpu_addr = a;
        repeat (4) @(negedge ref_clk);
        d = cpu_data_out;
        chk_val({7'h00, cpu_data_oe}, 8'h01, "data enable");
        cpu_cs_n = 1'b1;
        cpu_rd_n = 1'b1;
        repeat (4) @(negedge ref_clk);
    endtask

    // Read and compare of a register under a mask.
    task automatic chk_reg(input logic [4:0] a, input logic [7:0] m, input logic [7:0] exp);
        logic [7:0] d;
        cpu_read(a, d);
        chk_val(d & m, exp, $sformatf("register %h", a));
    endtask

    // Run until a given number of milliseconds since reset release.
    task automatic at_ms(input int t);
        while (cyc < t * MS) begin
            @(negedge ref_clk);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog sized well beyond the longest test sequence.
    initial begin
        repeat (1100 * MS + 2000) @(posedge ref_clk);
        n_fail++;
        report_and_stop();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Test sequence.
    initial begin
        n_fail   = 0;
        compares = 0;
        rst_n    = 1'b0;
        cpu_cs_n = 1'b1;
        cpu_rd_n = 1'b1;
        cpu_addr = 5'h00;
        rx       = '{basic_loss: 1'b1, sig_multiframe_loss: 1'b1, crc4_multiframe_loss: 1'b1,
                     crc4_sync: 1'b0, non_normal: 1'b0, all_ones_alarm: 1'b0};
        cfg      = '{maintenance: 1'b1, auto_interwork: 1'b0, free_run: 1'b0};
        repeat (2) @(negedge ref_clk);
        rst_n = 1'b1;
        @(negedge ref_clk);
        chk_reg(5'h10, 8'hff, 8'he0);
        chk_reg(5'h14, 8'hff, 8'h00);
        far.send_fas(8'h9b);
        chk_reg(5'h11, 8'hff, 8'h9b);
        chk_reg(5'h11, 8'hff, 8'h9b);
        far.send_fas(8'h1b);
        chk_reg(5'h11, 8'hff, 8'h1b);
        far.send_nfas(8'h6a);
        chk_reg(5'h13, 8'hff, 8'h6a);
        far.send_nfas(8'hb5);
        chk_reg(5'h13, 8'hff, 8'hb5);
        far.send_ebits(2'b10);
        chk_reg(5'h10, 8'hff, 8'hf0);
        far.send_ebits(2'b01);
        chk_reg(5'h10, 8'hff, 8'he8);
        // Basic alignment found, CRC-4 search runs out after 8 ms.
        at_ms(2);
        rx.basic_loss          = 1'b0;
        rx.sig_multiframe_loss = 1'b0;
        at_ms(7);
        chk_reg(5'h10, 8'hff, 8'h28);
        at_ms(13);
        chk_reg(5'h10, 8'hff, 8'h2c);
        chk_val(8'(n_force), 8'h01, "frame search requests");
        at_ms(14);
        rx.crc4_multiframe_loss = 1'b0;
        at_ms(15);
        chk_reg(5'h10, 8'hff, 8'h09);
        chk_reg(5'h12, 8'h3c, 8'h14);
        // Received CRC-4 sync restarts the ms base while aligned, so a second pulse is the only toggle.
        rx.crc4_sync = 1'b1;
        @(negedge ref_clk);
        rx.crc4_sync = 1'b0;
        cpu_read(5'h12, d1);
        rx.crc4_sync = 1'b1;
        @(negedge ref_clk);
        rx.crc4_sync = 1'b0;
        cpu_read(5'h12, d2);
        chk_val({7'h00, d1[1] ^ d2[1]}, 8'h01, "sync ms toggle");
        // Long loss of basic alignment with non-normal frames.
        at_ms(16);
        rx.basic_loss           = 1'b1;
        rx.sig_multiframe_loss  = 1'b1;
        rx.crc4_multiframe_loss = 1'b1;
        rx.non_normal           = 1'b1;
        at_ms(17);
        chk_reg(5'h12, 8'h10, 8'h00);
        at_ms(110);
        chk_reg(5'h10, 8'hff, 8'he9);
        at_ms(120);
        chk_reg(5'h10, 8'hff, 8'heb);
        chk_reg(5'h12, 8'h30, 8'h20);
        at_ms(121);
        rx.basic_loss          = 1'b0;
        rx.sig_multiframe_loss = 1'b0;
        rx.non_normal          = 1'b0;
        at_ms(123);
        chk_reg(5'h10, 8'hff, 8'h29);
        at_ms(135);
        chk_reg(5'h10, 8'hff, 8'h2d);
        chk_val(8'(n_force), 8'h02, "frame search requests");
        chk_reg(5'h12, 8'h3c, 8'h10);
        // The 400 ms search timer ends interworking; half-second toggle at 500 ms.
        at_ms(525);
        chk_reg(5'h10, 8'hff, 8'h2c);
        chk_reg(5'h12, 8'hfc, 8'h98);
        // With automatic interworking the next 8 ms expiry toggles but requests no search.
        cfg.auto_interwork = 1'b1;
        at_ms(530);
        chk_reg(5'h12, 8'h04, 8'h04);
        chk_val(8'(n_force), 8'h02, "frame search requests");
        // All-ones alarm held long enough for keep-alive.
        rx.all_ones_alarm = 1'b1;
        at_ms(620);
        chk_reg(5'h12, 8'h01, 8'h00);
        at_ms(640);
        chk_reg(5'h12, 8'h01, 8'h01);
        rx.all_ones_alarm = 1'b0;
        at_ms(642);
        chk_reg(5'h12, 8'h01, 8'h00);
        // Both second timers turn over at 1000 ms.
        at_ms(1010);
        chk_reg(5'h12, 8'hc0, 8'h40);
        // Two reads started exactly one millisecond apart see the ms bit flipped.
        cpu_read(5'h12, d1);
        repeat (MS - 8) @(negedge ref_clk);
        cpu_read(5'h12, d2);
        chk_val({7'h00, d1[1] ^ d2[1]}, 8'h01, "ms toggle");
        // Free-running mode holds the second timers and the loss and regain persistence bits low.
        cfg.free_run = 1'b1;
        at_ms(1014);
        chk_reg(5'h12, 8'hf0, 8'h00);
        chk_val(8'(n_force), 8'h02, "frame search requests");
        report_and_stop();
    end
endmodule
